/* emb_regs.svh */
// constants of the external memory bus block: field positions, reset values and cycle counts
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

`define EMB_ADDR_W       24
`define EMB_AREA_MSB     23
`define EMB_AREA_LSB     22
`define EMB_DRAM_AREA    2'h3
`define EMB_ROW_MSB      21
`define EMB_ROW_LSB      9
`define EMB_COL_MSB      8
`define EMB_COL_LSB      0
`define EMB_STROBE_LAST  3'h3
`define EMB_DIV8_LAST    5'h03
`define EMB_DIV32_LAST   5'h0F
`define EMB_FIFO_DEPTH   8
`define EMB_STRAP_RST    1'b0
`define EMB_SYNC_W       37

`endif

/* emb_pkg.sv */
// types shared by the external memory bus block
package emb_pkg;

   typedef enum logic [1:0] {
      EMB_CLK_DIV8,
      EMB_CLK_DIV32,
      EMB_CLK_SUB,
      EMB_CLK_OFF
   } emb_clksel_e;

   typedef enum {
      S_IDLE,
      S_ADDR,
      S_DATA,
      S_ROW,
      S_COL,
      S_FIN,
      S_HOLD
   } emb_state_e;

   typedef struct packed {
      logic        write;
      logic [1:0]  be;
      logic [23:0] addr;
      logic [15:0] wdata;
   } emb_req_s;

   typedef struct packed {
      logic [23:0] addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } emb_beat_s;

   typedef struct packed {
      logic [7:0]  ad_lo_out;
      logic        ad_lo_oe;
      logic [7:0]  ad_mid_out;
      logic        ad_mid_oe;
      logic [7:0]  d_lo_out;
      logic        d_lo_oe;
      logic [7:0]  d_hi_out;
      logic        d_hi_oe;
      logic [7:0]  addr_hi_out;
      logic        addr_hi_oe;
      logic [3:0]  area_n;
      logic        ale;
      logic        rd_n;
      logic        even_n;
      logic        odd_n;
      logic        ras_n;
      logic        cas_even_n;
      logic        cas_odd_n;
      logic        dw_n;
      logic [12:0] mux_addr;
      logic        grant_n;
   } emb_pins_s;

endpackage

/* emb_stream_if.sv */
// valid/ready word stream between the bus block and its request fifo
`timescale 1ns/1ps
`default_nettype none
interface emb_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* emb_fifo.sv */
// request fifo: flip-flop storage, registered ready and valid flags
`timescale 1ns/1ps
`default_nettype none
module emb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic   clk,
   input  wire logic   reset_n,
   emb_stream_if.snk   wr,
   emb_stream_if.src   rd
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic [AW:0]      nxt_count;
   logic             ready_ff;
   logic             valid_ff;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // handshakes on both sides
   wire push = wr.valid && ready_ff;
   wire pop  = valid_ff && rd.ready;

   assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign wr.ready  = ready_ff;
   assign rd.valid  = valid_ff;
   assign rd.data   = mem_ff[rd_ptr_ff];

   // flags are registered so the source sees a clean ready
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
         ready_ff  <= 1'b0;
         valid_ff  <= 1'b0;
      end else begin
         wr_ptr_ff <= push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
         rd_ptr_ff <= pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
         count_ff  <= nxt_count;
         ready_ff  <= nxt_count < (AW+1)'(DEPTH);
         valid_ff  <= nxt_count != '0;
      end
   end

   // storage has no reset, only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= wr.data;
      end
   end
endmodule
`default_nettype wire

/* emb_ext_bus.sv */
// external memory bus block: request fifo, bus sequencer, strobes, dram and clock out
//
// Behaviour
// [R01] boot strap low: single-chip or expansion; high: microprocessor mode, bus on
// [R02] width strap low selects 16-bit data bus, high selects 8-bit
// [R03] while reset_n is low the block stays in reset
// [R04] separate bus: low data byte on first 8 pins, high byte on second
// [R05] multiplexed bus: low address byte then low data byte on same pins
// [R06] 16-bit multiplexed bus: middle address byte then high data byte
// [R07] upper address byte driven with its top bit inverted
// [R08] four area select outputs name the area of the current access
// [R09] dram access: row then column address on dram address pins
// [R10] clock out: main clock divided by 8 or 32, or sub clock
// [R11] dual strobe 16-bit: even strobe low writes even, odd strobe odd
// [R12] read strobe low during external reads in either strobe mode
// [R13] single strobe: write strobe low writes; lane enable low on odd access
// [R14] system should pick single strobe when all memories are 8-bit
// [R15] hold request low keeps block in hold with grant acknowledge low
// [R16] address latch pulse lets outside logic capture multiplexed address
// [R17] ready input low holds the access in its wait state
// [R18] dram: row strobe latches row, dram store strobe low writes
// [R19] dram: even column strobe for even bytes, odd for odd bytes
// [R20] address latch pulses only in address phase, before data turnaround
`timescale 1ns/1ps
`default_nettype none
`include "emb_regs.svh"
module emb_ext_bus (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                boot_mode_pin,
   input  wire logic                bus_width_pin,
   input  wire logic                mem_expand_en,
   input  wire logic                mux_bus_en,
   input  wire logic                single_strobe_en,
   input  wire logic                dram_area_en,
   input  wire emb_pkg::emb_clksel_e clk_sel,
   input  wire logic                sub_osc_in,
   input  wire logic                bus_hold_req_n,
   input  wire logic                bus_ready,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire logic                req_write,
   input  wire logic [1:0]          req_be,
   input  wire logic [23:0]         req_addr,
   input  wire logic [15:0]         req_wdata,
   output logic                     rsp_valid,
   output logic [15:0]              rsp_rdata,
   input  wire logic [7:0]          ad_lo_in,
   output logic [7:0]               ad_lo_out,
   output logic                     ad_lo_oe,
   input  wire logic [7:0]          ad_mid_in,
   output logic [7:0]               ad_mid_out,
   output logic                     ad_mid_oe,
   input  wire logic [7:0]          d_lo_in,
   output logic [7:0]               d_lo_out,
   output logic                     d_lo_oe,
   input  wire logic [7:0]          d_hi_in,
   output logic [7:0]               d_hi_out,
   output logic                     d_hi_oe,
   output logic [7:0]               addr_hi_out,
   output logic                     addr_hi_oe,
   output logic [3:0]               area_select_n,
   output logic                     addr_latch,
   output logic                     read_strobe_n,
   output logic                     even_byte_store_strobe_n,
   output logic                     odd_byte_store_strobe_n,
   output logic                     row_strobe_n,
   output logic                     col_strobe_even_n,
   output logic                     col_strobe_odd_n,
   output logic                     dram_store_strobe_n,
   output logic [12:0]              dram_mux_addr,
   output logic                     bus_grant_ack_n,
   output logic                     divided_clock_out
);
   import emb_pkg::*;

   localparam int REQ_W = $bits(emb_req_s);
   localparam emb_pins_s PINS_RST = '{ad_lo_out: 8'h00, ad_mid_out: 8'h00, d_lo_out: 8'h00,
      d_hi_out: 8'h00, addr_hi_out: 8'h00, area_n: 4'hF, mux_addr: 13'h0000,
      ale: 1'b0, ad_lo_oe: 1'b0, ad_mid_oe: 1'b0, d_lo_oe: 1'b0, d_hi_oe: 1'b0,
      addr_hi_oe: 1'b0, default: 1'b1};

   emb_stream_if #(.WIDTH(REQ_W)) push_if ();
   emb_stream_if #(.WIDTH(REQ_W)) pop_if ();

   logic [`EMB_SYNC_W-1:0] sync1_ff;
   logic [`EMB_SYNC_W-1:0] sync2_ff;
   logic                   boot_mp_ff;
   logic                   bus8_ff;
   emb_state_e             state_ff;
   emb_state_e             nxt_state;
   emb_req_s               req_ff;
   emb_beat_s              cur_ff;
   emb_beat_s              nxt_cur;
   logic                   write_ff;
   logic                   rest_ff;
   logic                   nxt_rest;
   logic [2:0]             cnt_ff;
   logic [15:0]            rdata_ff;
   logic [15:0]            nxt_rdata;
   logic                   rsp_valid_ff;
   logic [15:0]            rsp_rdata_ff;
   emb_pins_s              pins_ff;
   emb_pins_s              nxt_pins;
   logic [4:0]             div_cnt_ff;
   logic                   clk_out_ff;
   logic                   nxt_clk_out;

   // user requests enter the fifo; a full fifo pushes back on req_ready
   assign push_if.valid = req_valid;
   assign push_if.data  = {req_write, req_be, req_addr, req_wdata};
   assign req_ready     = push_if.ready;

   emb_fifo #(.WIDTH(REQ_W), .DEPTH(`EMB_FIFO_DEPTH)) u_req_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .wr      (push_if.snk),
      .rd      (pop_if.src)
   );

   // pins from outside pass two flip-flops; only the second stage is read
   always_ff @(posedge clk) begin
      sync1_ff <= {boot_mode_pin, bus_width_pin, bus_hold_req_n, bus_ready, sub_osc_in,
                   ad_lo_in, ad_mid_in, d_lo_in, d_hi_in};
      sync2_ff <= sync1_ff;
   end

   wire       boot_s  = sync2_ff[36];
   wire       width_s = sync2_ff[35];
   wire       hold_n_s = sync2_ff[34];
   wire       ready_s = sync2_ff[33];
   wire       sub_s   = sync2_ff[32];
   wire [7:0] ad_lo_s = sync2_ff[31:24];
   wire [7:0] ad_mid_s = sync2_ff[23:16];
   wire [7:0] d_lo_s  = sync2_ff[15:8];
   wire [7:0] d_hi_s  = sync2_ff[7:0];

   // straps follow the pins while reset is held and freeze at release
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         boot_mp_ff <= boot_s; // [R01]
         bus8_ff    <= width_s; // [R02]
      end
   end

   function automatic logic [1:0] area_of(input logic [23:0] a);
      area_of = a[`EMB_AREA_MSB:`EMB_AREA_LSB];
   endfunction

   function automatic logic dram_hit(input logic [23:0] a, input logic en);
      dram_hit = en && (area_of(a) == `EMB_DRAM_AREA);
   endfunction

   // on the 8-bit bus every byte is its own beat and rides the low lane
   function automatic emb_beat_s beat_of(input emb_req_s r, input logic odd);
      beat_of.addr  = {r.addr[23:1], odd};
      beat_of.be    = odd ? 2'h2 : 2'h1;
      beat_of.wdata = {8'h00, odd ? r.wdata[15:8] : r.wdata[7:0]};
   endfunction

   // decode of sequencer conditions
   emb_req_s head;
   assign head = emb_req_s'(pop_if.data);
   wire bus_on   = boot_mp_ff || mem_expand_en; // [R01]
   wire idle_ok  = (state_ff == S_IDLE) && hold_n_s;
   wire load     = idle_ok && pop_if.valid;
   wire second   = (state_ff == S_FIN) && rest_ff;
   wire data_ph  = (state_ff == S_DATA) || (state_ff == S_COL);
   wire wait_end = cnt_ff == `EMB_STROBE_LAST;
   wire capture  = data_ph && wait_end && ready_s && !write_ff;
   wire [7:0] in_lo = mux_bus_en ? ad_lo_s : d_lo_s;
   wire [7:0] in_hi = bus8_ff ? in_lo : (mux_bus_en ? ad_mid_s : d_hi_s);
   wire [15:0] merged = {cur_ff.be[1] ? in_hi : rdata_ff[15:8],
                         cur_ff.be[0] ? in_lo : rdata_ff[7:0]};
   wire emb_beat_s first = bus8_ff ? beat_of(head, !head.be[0])
                                   : emb_beat_s'({head.addr, head.be, head.wdata}); // [R02]

   assign pop_if.ready = idle_ok;
   assign nxt_cur   = load ? first : (second ? beat_of(req_ff, 1'b1) : cur_ff);
   assign nxt_rest  = load ? (bus8_ff && head.be[0] && head.be[1]) : (second ? 1'b0 : rest_ff);
   assign nxt_rdata = load ? 16'h0000 : (capture ? merged : rdata_ff);

   // bus sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (!hold_n_s) begin
               nxt_state = S_HOLD; // [R15]
            end else if (pop_if.valid) begin
               nxt_state = !bus_on ? S_FIN : (dram_hit(head.addr, dram_area_en) ? S_ROW : S_ADDR);
            end
         end
         S_ADDR:  nxt_state = S_DATA;
         S_ROW:   nxt_state = S_COL;
         S_DATA, S_COL: begin
            if (wait_end && ready_s) begin
               nxt_state = S_FIN; // [R17]
            end
         end
         S_FIN: begin
            if (rest_ff) begin
               nxt_state = dram_hit(cur_ff.addr, dram_area_en) ? S_ROW : S_ADDR;
            end else begin
               nxt_state = S_IDLE;
            end
         end
         S_HOLD: begin
            if (hold_n_s) begin
               nxt_state = S_IDLE; // [R15]
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   // sequencer state; reset parks it idle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= S_IDLE; // [R03]
         cnt_ff   <= 3'h0;
         rest_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= (data_ph && !wait_end) ? cnt_ff + 3'h1 : (data_ph ? cnt_ff : 3'h0);
         rest_ff  <= nxt_rest;
      end
   end

   // request datapath
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         req_ff   <= '0;
         cur_ff   <= '0;
         write_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         req_ff   <= load ? head : req_ff;
         write_ff <= load ? head.write : write_ff;
         cur_ff   <= nxt_cur;
         rdata_ff <= nxt_rdata;
      end
   end

   // answer pulses once the last beat is done
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= 16'h0000;
      end else begin
         rsp_valid_ff <= (state_ff == S_FIN) && !rest_ff;
         rsp_rdata_ff <= ((state_ff == S_FIN) && !rest_ff) ? rdata_ff : rsp_rdata_ff;
      end
   end

   // pin decode; address pins stay owned between accesses, released in hold
   wire own  = bus_on && (state_ff != S_HOLD);
   wire wr_d = write_ff && (state_ff == S_DATA);
   wire mux16 = mux_bus_en && !bus8_ff;
   wire lane_even = bus8_ff || cur_ff.be[0];
   wire lane_odd  = !bus8_ff && cur_ff.be[1];
   wire in_acc = (state_ff == S_ADDR) || (state_ff == S_DATA);
   wire in_dram = (state_ff == S_ROW) || (state_ff == S_COL);

   always_comb begin
      nxt_pins = PINS_RST;
      nxt_pins.ad_lo_out  = (mux_bus_en && data_ph) ? cur_ff.wdata[7:0] : cur_ff.addr[7:0]; // [R05]
      nxt_pins.ad_lo_oe   = own && !(mux_bus_en && data_ph && !write_ff); // [R05]
      nxt_pins.ad_mid_out = (mux16 && data_ph) ? cur_ff.wdata[15:8] : cur_ff.addr[15:8]; // [R06]
      nxt_pins.ad_mid_oe  = own && !(mux16 && data_ph && !write_ff); // [R06]
      nxt_pins.d_lo_out   = cur_ff.wdata[7:0]; // [R04]
      nxt_pins.d_lo_oe    = own && !mux_bus_en && data_ph && write_ff; // [R04]
      nxt_pins.d_hi_out   = cur_ff.wdata[15:8]; // [R04]
      nxt_pins.d_hi_oe    = own && !mux_bus_en && !bus8_ff && data_ph && write_ff; // [R04]
      nxt_pins.addr_hi_out = {~cur_ff.addr[23], cur_ff.addr[22:16]}; // [R07]
      nxt_pins.addr_hi_oe = own;
      nxt_pins.area_n     = (own && (in_acc || in_dram)) ?
                            ~(4'h1 << area_of(cur_ff.addr)) : 4'hF; // [R08]
      nxt_pins.ale        = own && (state_ff == S_ADDR); // [R16] [R20]
      nxt_pins.rd_n       = !(own && (state_ff == S_DATA) && !write_ff); // [R12]
      // single mode turns the even pin into the write strobe and the odd pin into lane enable
      nxt_pins.even_n     = single_strobe_en ? !(own && wr_d) : !(own && wr_d && lane_even); // [R11] [R13]
      nxt_pins.odd_n      = single_strobe_en ? !(own && in_acc && cur_ff.be[1])
                                             : !(own && wr_d && lane_odd); // [R11] [R13]
      nxt_pins.ras_n      = !(own && in_dram); // [R18]
      nxt_pins.cas_even_n = !(own && (state_ff == S_COL) && cur_ff.be[0]); // [R19]
      nxt_pins.cas_odd_n  = !(own && (state_ff == S_COL) && cur_ff.be[1]); // [R19]
      nxt_pins.dw_n       = !(own && (state_ff == S_COL) && write_ff); // [R18]
      nxt_pins.mux_addr   = (state_ff == S_COL) ? {4'h0, cur_ff.addr[`EMB_COL_MSB:`EMB_COL_LSB]}
                                           : cur_ff.addr[`EMB_ROW_MSB:`EMB_ROW_LSB]; // [R09]
      nxt_pins.grant_n    = state_ff != S_HOLD; // [R15]
   end

   // every pin leaves through a flip-flop, one cycle behind the sequencer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pins_ff <= PINS_RST;
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   // clock output divider; the sub clock is only sampled, so it must run below clk/4
   always_comb begin
      case (clk_sel)
         EMB_CLK_DIV8:  nxt_clk_out = (div_cnt_ff >= `EMB_DIV8_LAST) ? !clk_out_ff : clk_out_ff;
         EMB_CLK_DIV32: nxt_clk_out = (div_cnt_ff >= `EMB_DIV32_LAST) ? !clk_out_ff : clk_out_ff;
         EMB_CLK_SUB:   nxt_clk_out = sub_s;
         default:       nxt_clk_out = 1'b0;
      endcase
   end

   wire div_wrap = (clk_sel == EMB_CLK_DIV8) ? (div_cnt_ff >= `EMB_DIV8_LAST)
                                             : (div_cnt_ff >= `EMB_DIV32_LAST);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_cnt_ff <= 5'h00;
         clk_out_ff <= 1'b0;
      end else begin
         div_cnt_ff <= div_wrap ? 5'h00 : div_cnt_ff + 5'h01; // [R10]
         clk_out_ff <= nxt_clk_out; // [R10]
      end
   end

   assign rsp_valid = rsp_valid_ff;
   assign rsp_rdata = rsp_rdata_ff;
   assign ad_lo_out = pins_ff.ad_lo_out;
   assign ad_lo_oe  = pins_ff.ad_lo_oe;
   assign ad_mid_out = pins_ff.ad_mid_out;
   assign ad_mid_oe = pins_ff.ad_mid_oe;
   assign d_lo_out  = pins_ff.d_lo_out;
   assign d_lo_oe   = pins_ff.d_lo_oe;
   assign d_hi_out  = pins_ff.d_hi_out;
   assign d_hi_oe   = pins_ff.d_hi_oe;
   assign addr_hi_out = pins_ff.addr_hi_out;
   assign addr_hi_oe = pins_ff.addr_hi_oe;
   assign area_select_n = pins_ff.area_n;
   assign addr_latch = pins_ff.ale;
   assign read_strobe_n = pins_ff.rd_n;
   assign even_byte_store_strobe_n = pins_ff.even_n;
   assign odd_byte_store_strobe_n = pins_ff.odd_n;
   assign row_strobe_n = pins_ff.ras_n;
   assign col_strobe_even_n = pins_ff.cas_even_n;
   assign col_strobe_odd_n = pins_ff.cas_odd_n;
   assign dram_store_strobe_n = pins_ff.dw_n;
   assign dram_mux_addr = pins_ff.mux_addr;
   assign bus_grant_ack_n = pins_ff.grant_n;
   assign divided_clock_out = clk_out_ff;

   // checks next to the logic they guard
   a_reset_park: assert property (@(posedge clk) !reset_n |=> state_ff == S_IDLE) // [R03]
      else $error("sequencer not idle after reset");
   a_hold_grant: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == S_HOLD |=> !bus_grant_ack_n && !ad_lo_oe) // [R15]
      else $error("hold without grant acknowledge");
   a_latch_addr: assert property (@(posedge clk) disable iff (!reset_n)
      addr_latch |-> ad_lo_oe && ad_lo_out == cur_ff.addr[7:0] ##1 !addr_latch) // [R16] [R20]
      else $error("address latch outside address phase");
   a_ready_stall: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == S_DATA && !ready_s |=> state_ff == S_DATA) // [R17]
      else $error("access completed while not ready");
   a_read_strobe: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == S_DATA && !write_ff && bus_on |=> !read_strobe_n) // [R12]
      else $error("read strobe not low in read");
   a_even_store: assert property (@(posedge clk) disable iff (!reset_n)
      !single_strobe_en && !bus8_ff && wr_d && cur_ff.be[0] && bus_on
      |=> !even_byte_store_strobe_n) // [R11]
      else $error("even strobe missing");
   a_lane_enable: assert property (@(posedge clk) disable iff (!reset_n)
      single_strobe_en && in_acc && bus_on |=> odd_byte_store_strobe_n == !$past(cur_ff.be[1])) // [R13]
      else $error("lane enable wrong");
   a_upper_addr: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == S_ADDR |=> addr_hi_out == {~cur_ff.addr[23], cur_ff.addr[22:16]}) // [R07]
      else $error("upper address bit not inverted");
   a_dram_rowcol: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == S_ROW && bus_on |=> !row_strobe_n && col_strobe_even_n && col_strobe_odd_n
      && dram_mux_addr == cur_ff.addr[21:9] ##1 !row_strobe_n) // [R09] [R18] [R19]
      else $error("dram row phase wrong");
endmodule
`default_nettype wire

/* emb_mem_model.sv */
// far-side memory model: answers reads on the data pins, records odd-byte writes from the high data pins and dram rows
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [7:0]  ad_lo_out,
   input  wire logic [7:0]  addr_hi_out,
   input  wire logic [7:0]  d_hi_out,
   input  wire logic [3:0]  area_select_n,
   input  wire logic        addr_latch,
   input  wire logic        read_strobe_n,
   input  wire logic        odd_byte_store_strobe_n,
   input  wire logic        row_strobe_n,
   input  wire logic [12:0] dram_mux_addr,
   output logic [7:0]       rd_lo,
   output logic [7:0]       rd_hi,
   output logic             bus_ready,
   output logic [7:0]       lat,
   output logic [7:0]       hi_q,
   output logic [3:0]       area_q,
   output logic [7:0]       odd_q,
   output logic [12:0]      row_q
);
   logic [7:0] junk = 8'h00;
   logic [2:0] cnt  = 3'h0;
   logic       rd_q = 1'b1;
   logic       ras_q = 1'b1;
   // data only while the read strobe is low; otherwise a pattern flipping every cycle
   assign rd_lo     = !read_strobe_n ? (lat ^ 8'h3C) : junk;
   assign rd_hi     = !read_strobe_n ? (lat ^ 8'hC3) : ~junk;
   assign bus_ready = (cnt == 3'h0) && !(slow && rd_q && !read_strobe_n);
   // slow mode stalls each read for six cycles after the strobe falls
   always_ff @(posedge clk) begin
      junk  <= ~junk;
      rd_q  <= read_strobe_n;
      ras_q <= row_strobe_n;
      if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
      else if (slow && rd_q && !read_strobe_n)
         cnt <= 3'h6;
      if (addr_latch) begin
         lat    <= ad_lo_out;
         hi_q   <= addr_hi_out;
         area_q <= area_select_n;
      end
      if (!odd_byte_store_strobe_n)
         odd_q <= d_hi_out;
      if (ras_q && !row_strobe_n)
         row_q <= dram_mux_addr;
   end
endmodule
`default_nettype wire

/* emb_ext_bus_bench.sv */
// self-checking bench for the external memory bus block
`timescale 1ns/1ps
`default_nettype none
module emb_ext_bus_bench;
   import emb_pkg::*;
   logic clk, reset_n, mux, dram, hold_n, slow, req_valid, req_ready, req_write, rsp_valid;
   logic bus_ready, addr_latch, read_strobe_n, odd_byte_store_strobe_n, row_strobe_n;
   logic bus_grant_ack_n, divided_clock_out, width, single;
   logic [1:0] req_be;
   logic [3:0] area_select_n, area_q;
   logic [7:0] ad_lo_out, addr_hi_out, d_hi_out, rd_lo, rd_hi, lat, hi_q, odd_q;
   logic [12:0] dram_mux_addr, row_q;
   logic [15:0] req_wdata, rsp_rdata, rd;
   logic [23:0] req_addr;
   emb_clksel_e clk_sel;
   int fails, cmp_count, n, n0;
   emb_ext_bus uut (.clk, .reset_n, .boot_mode_pin(1'b1), .bus_width_pin(width),
      .mem_expand_en(1'b0), .mux_bus_en(mux), .single_strobe_en(single), .dram_area_en(dram),
      .clk_sel, .sub_osc_in(1'b0), .bus_hold_req_n(hold_n), .bus_ready, .req_valid,
      .req_ready, .req_write, .req_be, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
      .ad_lo_in(rd_lo), .ad_lo_out, .ad_lo_oe(), .ad_mid_in(rd_hi), .ad_mid_out(),
      .ad_mid_oe(), .d_lo_in(rd_lo), .d_lo_out(), .d_lo_oe(), .d_hi_in(rd_hi), .d_hi_out,
      .d_hi_oe(), .addr_hi_out, .addr_hi_oe(), .area_select_n, .addr_latch, .read_strobe_n,
      .even_byte_store_strobe_n(), .odd_byte_store_strobe_n, .row_strobe_n,
      .col_strobe_even_n(), .col_strobe_odd_n(), .dram_store_strobe_n(), .dram_mux_addr,
      .bus_grant_ack_n, .divided_clock_out);
   emb_mem_model mem (.clk, .slow, .ad_lo_out, .addr_hi_out, .d_hi_out, .area_select_n,
      .addr_latch, .read_strobe_n, .odd_byte_store_strobe_n, .row_strobe_n, .dram_mux_addr,
      .rd_lo, .rd_hi, .bus_ready, .lat, .hi_q, .area_q, .odd_q, .row_q);
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task tick; @(posedge clk); #1; endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // hold the request until an edge with ready high takes it
   task automatic req(input logic w, input logic [23:0] a, input logic [15:0] d);
      req_write = w; req_be = w ? 2'h2 : 2'h3; req_addr = a; req_wdata = d; req_valid = 1'b1;
      while (req_ready !== 1'b1) tick;
      tick;
      req_valid = 1'b0;
   endtask
   task rsp; n = 0; do begin tick; n++; end while (rsp_valid !== 1'b1); rd = rsp_rdata; endtask
   task automatic per(output int k);
      k = 0;
      while (divided_clock_out !== 1'b0) tick;
      while (divided_clock_out !== 1'b1) tick;
      do begin tick; k++; end while (divided_clock_out !== 1'b0);
      do begin tick; k++; end while (divided_clock_out !== 1'b1);
   endtask
   task t_reset;
      reset_n = 1'b0;
      repeat (20) tick;
      chk("area_idle", 24'hF, area_select_n);
      chk("grant_idle", 24'h1, bus_grant_ack_n);
      reset_n = 1'b1;
      repeat (3) tick;
      $display("test reset done");
   endtask
   task t_clk;
      per(n); per(n); chk("div8", 24'd8, n);
      clk_sel = EMB_CLK_DIV32;
      per(n); per(n); chk("div32", 24'd32, n);
      clk_sel = EMB_CLK_OFF; tick; chk("clk_off", 24'h0, divided_clock_out);
      $display("test clock out done");
   endtask
   task t_read;
      req(1'b0, 24'h400010, 16'h0); rsp; n0 = n;
      chk("rdata", {8'h10 ^ 8'hC3, 8'h10 ^ 8'h3C}, rd);
      chk("addr_hi", 24'hC0, hi_q);
      chk("area", 24'hD, area_q);
      slow = 1'b1; req(1'b0, 24'h000020, 16'h0); rsp; slow = 1'b0;
      chk("stall", 24'h1, n > n0 + 4);
      chk("slow_rdata", {8'h20 ^ 8'hC3, 8'h20 ^ 8'h3C}, rd);
      $display("test separate read done");
   endtask
   task t_write;
      req(1'b1, 24'h000011, 16'hBE00); rsp;
      chk("odd_lane", 24'hBE, odd_q);
      chk("wr_rsp", 24'h0, rd);
      $display("test odd write done");
   endtask
   task t_mux;
      mux = 1'b1; req(1'b0, 24'h000142, 16'h0); rsp; mux = 1'b0;
      chk("mux_latch", 24'h42, lat);
      chk("mux_rdata", {8'h42 ^ 8'hC3, 8'h42 ^ 8'h3C}, rd);
      dram = 1'b1; req(1'b0, 24'hC00203, 16'h0); rsp; dram = 1'b0;
      chk("dram_row", 24'h1, row_q);
      $display("test mux and dram done");
   endtask
   task t_fifo;
      hold_n = 1'b0; n = 0;
      while (bus_grant_ack_n !== 1'b0 && n < 20) begin tick; n++; end
      chk("grant", 24'h0, bus_grant_ack_n);
      req_write = 1'b0; req_be = 2'h3; req_addr = 24'h000030; req_valid = 1'b1; n = 0;
      while (req_ready === 1'b1 && n < 20) begin tick; n++; end
      req_valid = 1'b0;
      chk("fifo_depth", 24'd8, n);
      chk("grant_held", 24'h0, bus_grant_ack_n);
      hold_n = 1'b1;
      repeat (8) rsp;
      chk("drain_rdata", {8'h30 ^ 8'hC3, 8'h30 ^ 8'h3C}, rd);
      $display("test hold and fifo done");
   endtask
   task t_byte;
      width = 1'b1; single = 1'b1; t_reset;
      req(1'b0, 24'h000020, 16'h0); rsp;
      chk("byte_rdata", {8'h21 ^ 8'h3C, 8'h20 ^ 8'h3C}, rd);
      $display("test byte bus done");
   endtask
   // watchdog at 20000 cycles; the whole run needs well under that
   initial begin
      #2000000;
      fails++;
      final_report;
   end
   initial begin
      fails = 0; cmp_count = 0; reset_n = 1'b0; mux = 1'b0; dram = 1'b0; hold_n = 1'b1;
      slow = 1'b0; req_valid = 1'b0; req_write = 1'b0; req_be = 2'h0; req_addr = 24'h0;
      req_wdata = 16'h0; clk_sel = EMB_CLK_DIV8; width = 1'b0; single = 1'b0;
      t_reset; t_clk; t_read; t_write; t_mux; t_fifo; t_byte;
      final_report;
   end
endmodule
`default_nettype wire
